/* File: design/ipm_pkg.sv */
// Functional notes
// (RULE_01) After reset input A drives channel 2 and input B channel 3.
// (RULE_02) Software can reprogram either input's channel map to any channel set.
// (RULE_03) Each channel request is its output bit ORed with every mapped input.
// (RULE_04) Input pin levels are readable in the input level monitor register.
// (RULE_05) The input level monitor keeps working while in fallback mode.
// (RULE_06) Sleep pin low with any input high enters fallback with default channels.
// (RULE_07) Sleep pin low with both inputs low enters sleep mode.
// (RULE_08) Controller holds each new sleep pin level for the transition time.
// (RULE_09) Sleep pin low holds all software registers at their defaults.
// (RULE_10) Sleep pin low with inputs low disables both undervoltage detectors.
// (RULE_11) Sleep pin and inputs low refuse serial access; serial output floats.
// (RULE_12) Both supplies low block power stages, serial access, and clear registers.
// (RULE_13) Logic supply undervoltage blocks serial access and clears registers.
// (RULE_14) Power supply undervoltage turns all channels off until it recovers.
// (RULE_15) Below operating level, lit channels stay on; new turn-ons are refused.
// (RULE_16) A turn-on request outside active mode wakes to active or fallback.
// (RULE_17) Input and sleep pins pass a two-stage synchroniser before use.
package ipm_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  ADDR_OUT      = 8'h00;
   localparam logic [7:0]  ADDR_MAP_A    = 8'h04;
   localparam logic [7:0]  ADDR_MAP_B    = 8'h08;
   localparam logic [7:0]  ADDR_MONITOR  = 8'h0C;
   localparam logic [7:0]  ADDR_STATUS   = 8'h10;

   // ----------------------------------------------------------------------
   // Field positions and defaults
   // ----------------------------------------------------------------------
   localparam int          NUM_CH        = 8;
   localparam int          DEF_CH_A      = 2;
   localparam int          DEF_CH_B      = 3;
   localparam int          MON_A_BIT     = 0;
   localparam int          MON_B_BIT     = 1;
   localparam int          STAT_MODE_LSB = 0;
   localparam int          STAT_VS_UV    = 4;
   localparam int          STAT_VS_LOW   = 5;
   localparam int          STAT_VDD_UV   = 6;
   localparam int          STAT_UV_DET   = 7;
   localparam int          SYNC_STAGES   = 2;

   typedef enum logic [3:0] {
      IPM_SLEEP  = 4'h1,
      IPM_IDLE   = 4'h2,
      IPM_ACTIVE = 4'h4,
      IPM_LIMP   = 4'h8
   } ipm_mode_t;

endpackage

/* File: design/ipm_sync.sv */
`timescale 1ns/1ps
module ipm_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             clk,    // System clock.
   input  wire logic             sys_rst, // Synchronous reset, active high.
   input  wire logic [WIDTH-1:0] d,      // Asynchronous levels.
   output logic      [WIDTH-1:0] q       // Synchronised levels.
);

   // ----------------------------------------------------------------------
   // Two-stage synchroniser; the first stage feeds only the second.
   // ----------------------------------------------------------------------
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

/* File: design/ipm_ctrl.sv */
`timescale 1ns/1ps
module ipm_ctrl #(
   parameter int NUM_CH = ipm_pkg::NUM_CH
) (
   input  wire logic              clk,            // System clock, 50 MHz.
   input  wire logic              sys_rst,        // Synchronous reset, active high.
   input  wire logic [7:0]        paddr,          // APB address.
   input  wire logic              psel,           // APB select.
   input  wire logic              penable,        // APB enable.
   input  wire logic              pwrite,         // APB direction, high for write.
   input  wire logic [31:0]       pwdata,         // APB write data.
   output logic      [31:0]       prdata,         // APB read data.
   output logic                   pready,         // APB ready.
   output logic                   pslverr,        // APB error.
   input  wire logic              direct_input_a, // Direct input pin A.
   input  wire logic              direct_input_b, // Direct input pin B.
   input  wire logic              sleep_ctrl_pin, // Sleep control pin, low to sleep.
   input  wire logic              vs_below_uv,    // Power supply under its UV level.
   input  wire logic              vs_below_op,    // Power supply under its operating level.
   input  wire logic              vdd_below_uv,   // Logic supply under its UV level.
   input  wire logic              select_low_pin, // Serial chip select, active low.
   output logic      [NUM_CH-1:0] channel_drive,  // Power stage drive per channel.
   output logic                   serial_out_oe_n, // Serial output enable, low drives.
   output logic                   uv_detect_en,   // Undervoltage detectors enabled.
   output logic      [3:0]        mode_state      // Current one-hot operating mode.
);

   localparam logic [NUM_CH-1:0] MAP_A_DEF = NUM_CH'(1) << ipm_pkg::DEF_CH_A;
   localparam logic [NUM_CH-1:0] MAP_B_DEF = NUM_CH'(1) << ipm_pkg::DEF_CH_B;

   // ----------------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------------
   logic [2:0] pins_s;
   wire        in_a_s  = pins_s[0];
   wire        in_b_s  = pins_s[1];
   wire        sleep_s = pins_s[2];

   ipm_sync #(.WIDTH(3)) u_sync ( // RULE_17
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       ({sleep_ctrl_pin, direct_input_b, direct_input_a}),
      .q       (pins_s)
   );

   // ----------------------------------------------------------------------
   // Supply and access conditions
   // ----------------------------------------------------------------------
   // Detectors are off in deep sleep, so their flags are ignored there.
   wire any_in     = in_a_s | in_b_s;
   wire deep_sleep = ~sleep_s & ~any_in;
   wire uv_det_w   = ~deep_sleep;                         // RULE_10
   wire vs_uv_eff  = vs_below_uv & uv_det_w;
   wire vs_low_eff = vs_below_op & uv_det_w;
   wire vdd_uv_eff = vdd_below_uv & uv_det_w;
   wire ser_block  = deep_sleep | vdd_uv_eff;             // RULE_11 RULE_12 RULE_13
   wire reg_clear  = ~sleep_s | vdd_uv_eff;               // RULE_09 RULE_12 RULE_13

   // ----------------------------------------------------------------------
   // APB slave, no wait states: setup cycle loads the answer
   // ----------------------------------------------------------------------
   logic [NUM_CH-1:0] out_q, map_a_q, map_b_q;
   logic [NUM_CH-1:0] drive_q, drive_d;
   ipm_pkg::ipm_mode_t mode_q, mode_d;
   logic [31:0]       prdata_q;
   logic              pready_q, pslverr_q, oe_n_q, uv_det_q;

   wire setup    = psel & ~penable;
   wire hit_out  = paddr == ipm_pkg::ADDR_OUT;
   wire hit_mapa = paddr == ipm_pkg::ADDR_MAP_A;
   wire hit_mapb = paddr == ipm_pkg::ADDR_MAP_B;
   wire hit_mon  = paddr == ipm_pkg::ADDR_MONITOR;
   wire hit_stat = paddr == ipm_pkg::ADDR_STATUS;
   wire mapped   = hit_out | hit_mapa | hit_mapb | hit_mon | hit_stat;
   wire wr_ok    = psel & penable & pready_q & pwrite & ~ser_block & ~pslverr_q;
   wire bad_req  = ~mapped | ser_block | (pwrite & (hit_mon | hit_stat));

   wire [31:0] mon_word  = 32'(  {in_b_s, in_a_s}); // RULE_04 RULE_05
   wire [31:0] stat_word = 32'({uv_det_w, vdd_uv_eff, vs_low_eff, vs_uv_eff, mode_q});
   wire [31:0] rd_mux    = ser_block ? 32'h0000_0000 :
                           hit_out   ? 32'(out_q)   :
                           hit_mapa  ? 32'(map_a_q) :
                           hit_mapb  ? 32'(map_b_q) :
                           hit_mon   ? mon_word     :
                           hit_stat  ? stat_word    : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & bad_req;
         prdata_q  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst || reg_clear) begin                     // RULE_09
         out_q   <= '0;
         map_a_q <= MAP_A_DEF;                            // RULE_01
         map_b_q <= MAP_B_DEF;
      end else if (wr_ok) begin                           // RULE_02
         if (hit_out)  out_q   <= pwdata[NUM_CH-1:0];
         if (hit_mapa) map_a_q <= pwdata[NUM_CH-1:0];
         if (hit_mapb) map_b_q <= pwdata[NUM_CH-1:0];
      end
   end

   // ----------------------------------------------------------------------
   // Channel request and drive
   // ----------------------------------------------------------------------
   logic [NUM_CH-1:0] req;

   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      // In fallback the registers are held at default, so only default maps apply.
      assign req[i] = (mode_q == ipm_pkg::IPM_LIMP) ?
                      ((in_a_s & MAP_A_DEF[i]) | (in_b_s & MAP_B_DEF[i])) :   // RULE_06
                      (out_q[i] | (in_a_s & map_a_q[i]) | (in_b_s & map_b_q[i])); // RULE_03
      // Between the two power supply thresholds a lit channel may stay lit only.
      assign drive_d[i] = req[i] & ~vs_uv_eff & (drive_q[i] | ~vs_low_eff) & // RULE_14 RULE_15
                          ((mode_q == ipm_pkg::IPM_ACTIVE) | (mode_q == ipm_pkg::IPM_LIMP));
   end

   // ----------------------------------------------------------------------
   // Operating mode
   // ----------------------------------------------------------------------
   always_comb begin
      case (mode_q)
         ipm_pkg::IPM_SLEEP,
         ipm_pkg::IPM_IDLE,
         ipm_pkg::IPM_ACTIVE,
         ipm_pkg::IPM_LIMP: begin
            if (!sleep_s) begin
               mode_d = any_in ? ipm_pkg::IPM_LIMP : ipm_pkg::IPM_SLEEP; // RULE_06 RULE_07
            end else if (|req || mode_q == ipm_pkg::IPM_ACTIVE && |out_q) begin
               mode_d = ipm_pkg::IPM_ACTIVE;                             // RULE_16
            end else begin
               mode_d = ipm_pkg::IPM_IDLE;
            end
         end
         default: mode_d = ipm_pkg::IPM_SLEEP;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_q   <= ipm_pkg::IPM_SLEEP;
         drive_q  <= '0;
         oe_n_q   <= 1'b1;
         uv_det_q <= 1'b0;
      end else begin
         mode_q   <= mode_d;
         drive_q  <= drive_d;
         oe_n_q   <= ser_block | select_low_pin;          // RULE_11
         uv_det_q <= uv_det_w;                            // RULE_10
      end
   end

   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign channel_drive   = drive_q;
   assign serial_out_oe_n = oe_n_q;
   assign uv_detect_en    = uv_det_q;
   assign mode_state      = mode_q;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_default_map: assert property (reg_clear |=> map_a_q == MAP_A_DEF && map_b_q == MAP_B_DEF) // RULE_01
      else $error("maps not at default after clear");
   a_map_write: assert property (wr_ok && hit_mapa && !reg_clear |=> map_a_q == $past(pwdata[NUM_CH-1:0])) // RULE_02
      else $error("map A write lost");
   a_drive_or: assert property (mode_q == ipm_pkg::IPM_ACTIVE && !vs_low_eff && !vs_uv_eff
                                |=> channel_drive == $past(out_q | ({NUM_CH{in_a_s}} & map_a_q)
                                                           | ({NUM_CH{in_b_s}} & map_b_q))) // RULE_03
      else $error("channel drive is not the OR of its sources");
   a_monitor_read: assert property (setup && !pwrite && hit_mon && !ser_block
                                    |=> prdata[1:0] == $past({in_b_s, in_a_s})) // RULE_04 RULE_05
      else $error("monitor read wrong");
   a_limp_entry: assert property (!sleep_s && any_in |=> mode_state == ipm_pkg::IPM_LIMP) // RULE_06
      else $error("fallback not entered");
   a_sleep_entry: assert property (deep_sleep |=> mode_state == ipm_pkg::IPM_SLEEP) // RULE_07
      else $error("sleep not entered");
   a_sleep_clear: assert property (!sleep_s |=> out_q == '0) // RULE_09
      else $error("registers not cleared in sleep");
   a_uv_det_off: assert property (deep_sleep |=> !uv_detect_en) // RULE_10
      else $error("detectors left on in sleep");
   a_serial_hiz: assert property (deep_sleep |=> serial_out_oe_n) // RULE_11
      else $error("serial output driven in sleep");
   a_vdd_block: assert property (vdd_uv_eff && setup |=> pslverr && out_q == '0) // RULE_12 RULE_13
      else $error("serial access during logic undervoltage");
   a_vs_uv_off: assert property (vs_uv_eff |=> channel_drive == '0) // RULE_14
      else $error("channel on during power undervoltage");
   a_hold_on: assert property (vs_low_eff |=> (channel_drive & ~$past(channel_drive)) == '0) // RULE_15
      else $error("new turn-on below operating level");
   a_wake_active: assert property (sleep_s && |req && mode_q != ipm_pkg::IPM_ACTIVE
                                   |=> mode_state == ipm_pkg::IPM_ACTIVE) // RULE_16
      else $error("no wake to active");
   a_pin_sync: assert property (##2 sleep_s == $past(sleep_ctrl_pin, 2)) // RULE_17
      else $error("sleep pin not synchronised in two stages");

   c_limp_drive: cover property (mode_q == ipm_pkg::IPM_LIMP && channel_drive[ipm_pkg::DEF_CH_A]);
   c_active_map: cover property (wr_ok && hit_mapb ##[1:20] channel_drive != '0);
   c_hold_low: cover property (vs_low_eff && channel_drive != '0);
   c_sleep_refuse: cover property (deep_sleep && setup && !select_low_pin);
   c_supply_back: cover property (vs_uv_eff ##1 !vs_uv_eff && !vs_low_eff ##[1:8] channel_drive != '0);

   // ----------------------------------------------------------------------
   // Bus protocol checks
   // ----------------------------------------------------------------------
   // Every setup is answered in the next cycle, so a waiting master never stalls.
   // The pulse must not stretch, or one request would be taken twice.
   a_ready_next: assert property (setup |=> pready)
      else $error("no ready after setup");

   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held for two cycles");

   a_rdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside access cycle");

   a_err_unmapped: assert property (setup && !mapped |=> pslverr)
      else $error("unmapped access not refused");

   a_err_readonly: assert property (setup && pwrite && (hit_mon || hit_stat) |=> pslverr)
      else $error("write to read-only register not refused");

   a_err_pulse: assert property (pslverr |-> pready)
      else $error("error without ready");

   // ----------------------------------------------------------------------
   // Serial access blocking
   // ----------------------------------------------------------------------
   a_block_refuse: assert property ( // RULE_11 RULE_13
      setup && ser_block |=> pslverr && prdata == 32'h0000_0000)
      else $error("blocked access answered");

   a_oe_driven: assert property (!ser_block && !select_low_pin |=> !serial_out_oe_n) // RULE_11
      else $error("serial output not driven when selected");

   a_oe_float: assert property (select_low_pin |=> serial_out_oe_n) // RULE_11
      else $error("serial output driven while deselected");

   a_vdd_clear: assert property ( // RULE_13
      vdd_uv_eff
      |=> out_q == '0 && map_a_q == MAP_A_DEF && map_b_q == MAP_B_DEF)
      else $error("registers kept during logic undervoltage");

   // ----------------------------------------------------------------------
   // Supply checks
   // ----------------------------------------------------------------------
   a_det_on: assert property (!deep_sleep |=> uv_detect_en) // RULE_10
      else $error("detectors off outside deep sleep");

   a_det_mask: assert property ( // RULE_10
      deep_sleep |-> !vs_uv_eff && !vs_low_eff && !vdd_uv_eff)
      else $error("undervoltage flag seen with detectors off");

   a_both_uv: assert property ( // RULE_12
      vs_uv_eff && vdd_uv_eff |=> channel_drive == '0 && out_q == '0)
      else $error("channel or register kept with both supplies low");

   a_vs_back: assert property ( // RULE_14
      !vs_uv_eff && !vs_low_eff && mode_q == ipm_pkg::IPM_ACTIVE
      |=> channel_drive == $past(req))
      else $error("channels not restored with supply at operating level");

   // ----------------------------------------------------------------------
   // Mode checks
   // ----------------------------------------------------------------------
   a_dark_modes: assert property ( // RULE_16
      mode_q == ipm_pkg::IPM_SLEEP || mode_q == ipm_pkg::IPM_IDLE |=> channel_drive == '0)
      else $error("channel driven outside active or fallback");

   a_limp_default: assert property ( // RULE_06
      mode_q == ipm_pkg::IPM_LIMP && !vs_uv_eff && !vs_low_eff
      |=> channel_drive == $past(({NUM_CH{in_a_s}} & MAP_A_DEF)
                                 | ({NUM_CH{in_b_s}} & MAP_B_DEF)))
      else $error("fallback drive is not the default mapping");

   a_idle_settle: assert property (
      sleep_s && !(|req) && !(|out_q) |=> mode_state == ipm_pkg::IPM_IDLE)
      else $error("idle not entered without requests");

   a_onehot_mode: assert property ($onehot(mode_state))
      else $error("mode is not one-hot");

   a_sync_in_a: assert property (##2 in_a_s == $past(direct_input_a, 2)) // RULE_17
      else $error("input A not synchronised in two stages");

   a_sync_in_b: assert property (##2 in_b_s == $past(direct_input_b, 2)) // RULE_17
      else $error("input B not synchronised in two stages");

   a_status_read: assert property (
      setup && !pwrite && hit_stat && !ser_block |=> prdata[3:0] == $past(mode_q))
      else $error("status read does not show the mode");

   a_monitor_limp: assert property ( // RULE_05
      mode_q == ipm_pkg::IPM_LIMP && setup && !pwrite && hit_mon && !ser_block
      |=> prdata[1:0] == $past({in_b_s, in_a_s}))
      else $error("monitor read wrong in fallback");

endmodule

/* File: test/ipm_ctl_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Controller model driving the direct pins
// ----------------------------------------------------------------------
module ipm_ctl_model #(
   parameter int HOLD = 4
) (
   input  wire logic clk,            // System clock.
   input  wire logic want_a,         // Requested level of input A.
   input  wire logic want_b,         // Requested level of input B.
   input  wire logic want_sleep_pin, // Requested sleep control level.
   output logic      direct_input_a, // Input pin A.
   output logic      direct_input_b, // Input pin B.
   output logic      sleep_ctrl_pin  // Sleep control pin.
);
   logic       a_q = 1'h0;
   logic       b_q = 1'h0;
   logic       sl_q = 1'h0;
   logic [3:0] hold_q = 4'h0;

   assign direct_input_a = a_q;
   assign direct_input_b = b_q;
   assign sleep_ctrl_pin = sl_q;

   // A new sleep level is only taken once the previous one has stood long enough.
   always @(posedge clk) begin
      a_q <= want_a;
      b_q <= want_b;
      if (hold_q != 4'h0) begin
         hold_q <= hold_q - 4'h1;
      end else if (want_sleep_pin != sl_q) begin
         sl_q   <= want_sleep_pin;
         hold_q <= 4'(HOLD);
      end
   end
endmodule

/* File: test/input_pin_mode_control_bench.sv */
`timescale 1ns/1ps
module input_pin_mode_control_bench;
   typedef struct packed {
      logic [7:0] o;
      logic [7:0] ma;
      logic [7:0] mb;
      logic       a;
      logic       b;
      logic [7:0] e;
   } ipm_row_t;

   logic        clk = 1'h0;
   logic        sys_rst = 1'h1;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        want_a = 1'h0;
   logic        want_b = 1'h0;
   logic        want_sl = 1'h0;
   logic        in_a;
   logic        in_b;
   logic        sleep_pin;
   logic        vs_uv = 1'h0;
   logic        vs_op = 1'h0;
   logic        vdd_uv = 1'h0;
   logic        sel_n = 1'h1;
   logic [7:0]  drive;
   logic        oe_n;
   logic        uv_en;
   logic [3:0]  mode;
   int          errors = 0;
   int          comparisons = 0;
   ipm_row_t    rows [6] = '{
      {8'h00, 8'h04, 8'h08, 1'h1, 1'h0, 8'h04}, {8'h00, 8'h04, 8'h08, 1'h0, 1'h1, 8'h08},
      {8'h01, 8'h30, 8'hC0, 1'h1, 1'h1, 8'hF1}, {8'h80, 8'h03, 8'h03, 1'h0, 1'h1, 8'h83},
      {8'h00, 8'hFF, 8'h00, 1'h1, 1'h0, 8'hFF}, {8'h10, 8'h0F, 8'hF0, 1'h0, 1'h0, 8'h10}};

   always #10 clk = ~clk;

   ipm_ctl_model i_ctl (.clk(clk), .want_a(want_a), .want_b(want_b), .want_sleep_pin(want_sl),
      .direct_input_a(in_a), .direct_input_b(in_b), .sleep_ctrl_pin(sleep_pin));

   ipm_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .direct_input_a(in_a), .direct_input_b(in_b), .sleep_ctrl_pin(sleep_pin),
      .vs_below_uv(vs_uv), .vs_below_op(vs_op), .vdd_below_uv(vdd_uv),
      .select_low_pin(sel_n), .channel_drive(drive), .serial_out_oe_n(oe_n),
      .uv_detect_en(uv_en), .mode_state(mode));

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // The request stays up until pready is seen at an edge; a hang ends the run.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) begin
         errors++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        s;
      apb(1'h1, a, d, r, s);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
      logic [31:0] r;
      logic        s;
      apb(1'h0, a, 32'h0, r, s);
      check(r, e);
      check({31'h0, s}, {31'h0, ee});
   endtask

   task automatic pins(input logic a, input logic b, input logic sl);
      want_a  <= a;
      want_b  <= b;
      want_sl <= sl;
      repeat (12) @(posedge clk);
   endtask

   task automatic drv(input logic [7:0] e);
      repeat (6) @(posedge clk);
      check({24'h0, drive}, {24'h0, e});
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      check({18'h0, drive, oe_n, uv_en, mode}, {18'h0, 8'h00, 1'h1, 1'h0, ipm_pkg::IPM_SLEEP});
      sys_rst <= 1'h0;
      pins(1'h0, 1'h0, 1'h1);
      rd_chk(ipm_pkg::ADDR_MAP_A, 32'h04, 1'h0);
      rd_chk(ipm_pkg::ADDR_MAP_B, 32'h08, 1'h0);
      rd_chk(8'h14, 32'h0, 1'h1);
      check({28'h0, mode}, {28'h0, ipm_pkg::IPM_IDLE});
      rd_chk(ipm_pkg::ADDR_STATUS, {24'h0, 1'h1, 3'h0, ipm_pkg::IPM_IDLE}, 1'h0);
      $display("Test reset and defaults done");
      for (int i = 0; i < 6; i++) begin
         wr(ipm_pkg::ADDR_OUT, {24'h0, rows[i].o});
         wr(ipm_pkg::ADDR_MAP_A, {24'h0, rows[i].ma});
         wr(ipm_pkg::ADDR_MAP_B, {24'h0, rows[i].mb});
         pins(rows[i].a, rows[i].b, 1'h1);
         check({24'h0, drive}, {24'h0, rows[i].e});
         check({28'h0, mode}, {28'h0, ipm_pkg::IPM_ACTIVE});
         rd_chk(ipm_pkg::ADDR_MONITOR, {30'h0, rows[i].b, rows[i].a}, 1'h0);
      end
      $display("Test mapping table done");
      pins(1'h0, 1'h0, 1'h0);
      check({24'h0, mode, 3'h0, uv_en}, {24'h0, ipm_pkg::IPM_SLEEP, 4'h0});
      sel_n <= 1'h0;
      rd_chk(ipm_pkg::ADDR_OUT, 32'h0, 1'h1);
      check({31'h0, oe_n}, 32'h1);
      sel_n  <= 1'h1;
      want_a <= 1'h1;
      repeat (3) @(posedge clk);
      check({31'h0, mode == ipm_pkg::IPM_LIMP}, 32'h0);
      pins(1'h1, 1'h0, 1'h0);
      check({20'h0, mode, drive}, {20'h0, ipm_pkg::IPM_LIMP, 8'h04});
      rd_chk(ipm_pkg::ADDR_MONITOR, 32'h1, 1'h0);
      rd_chk(ipm_pkg::ADDR_MAP_A, 32'h04, 1'h0);
      $display("Test sleep and fallback done");
      pins(1'h0, 1'h0, 1'h1);
      wr(ipm_pkg::ADDR_OUT, 32'h01);
      vs_uv <= 1'h1;
      drv(8'h00);
      vs_uv <= 1'h0;
      drv(8'h01);
      vs_op <= 1'h1;
      wr(ipm_pkg::ADDR_OUT, 32'h03);
      drv(8'h01);
      wr(ipm_pkg::ADDR_OUT, 32'h00);
      drv(8'h00);
      vs_op <= 1'h0;
      vdd_uv <= 1'h1;
      wr(ipm_pkg::ADDR_OUT, 32'h05);
      rd_chk(ipm_pkg::ADDR_MAP_B, 32'h0, 1'h1);
      vdd_uv <= 1'h0;
      rd_chk(ipm_pkg::ADDR_OUT, 32'h0, 1'h0);
      wr(ipm_pkg::ADDR_OUT, 32'h01);
      vs_uv  <= 1'h1;
      vdd_uv <= 1'h1;
      drv(8'h00);
      rd_chk(ipm_pkg::ADDR_OUT, 32'h0, 1'h1);
      $display("Test supply undervoltage done");
      print_verdict();
   end
endmodule
